/* File: rtl/tmc_defs.vh */
// Constants shared by the timer modulo and channel 0 control block
// Functional notes
// [RULE1] Up mode: counter at modulo wraps to zero, overflow set.
// [RULE2] Centre mode: counter at modulo turns down, overflow set.
// [RULE3] One modulo byte written holds off overflow until the other.
// [RULE4] Reset modulo zero; zero modulo means free running.
// [RULE5] Software rewrites modulo after overflow or clears the counter.
// [RULE6] Capture sets the flag on the selected pin edge.
// [RULE7] Compare or edge PWM sets the flag on value match.
// [RULE8] Centre PWM sets the flag on every match, up and down.
// [RULE9] Interrupt requested while flag and enable are both one.
// [RULE10] Flag clears by control read with flag set, then zero write.
// [RULE11] An event between read and write restarts the clear.
// [RULE12] Writing one to the flag does nothing; reset clears it.
// [RULE13] Interrupt enable read/write, reset zero; zero blocks requests.
// [RULE14] Centre off, mode bit B one: edge-aligned PWM.
// [RULE15] Centre off, mode bit B zero: bit A picks capture or compare.
// [RULE16] Edge/level field picks edge, compare action or PWM polarity.
// [RULE17] Edge/level 00 frees the pin for general I/O.
// [RULE18] Capture codes: 01 rising, 10 falling, 11 either edge.
// [RULE19] Compare codes: 00 none, 01 toggle, 10 clear, 11 set.
// [RULE20] PWM code 10 clears on match; x1 sets on match.
// [RULE21] Control bits 1:0 read zero; modulo reads last write.
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

// Register indices; byte address is four times the index
`define TMC_IDX_MODH      6'h13
`define TMC_IDX_MODL      6'h14
`define TMC_IDX_CTRL      6'h15

// Register select codes returned by the decoder
`define TMC_SEL_NONE      2'h0
`define TMC_SEL_MODH      2'h1
`define TMC_SEL_MODL      2'h2
`define TMC_SEL_CTRL      2'h3

// Channel control field positions
`define TMC_BIT_FLAG      7
`define TMC_BIT_IE        6
`define TMC_BIT_MSB       5
`define TMC_BIT_MSA       4
`define TMC_BIT_ELSB      3
`define TMC_BIT_ELSA      2

// Reset values and fixed codes
`define TMC_MOD_RST       16'h0000
`define TMC_CTRL_RST      5'h00
`define TMC_CNT_ZERO      16'h0000
`define TMC_CNT_FULL      16'hFFFF
`define TMC_CNT_ONE       16'h0001
`define TMC_ELS_OFF       2'h0
`define TMC_ELS_TOGGLE    2'h1
`define TMC_ELS_CLEAR     2'h2
`define TMC_ELS_SET       2'h3
`define TMC_MS_CAPTURE    2'h0
`define TMC_MS_COMPARE    2'h1

// AXI responses
`define TMC_RESP_OKAY     2'h0
`define TMC_RESP_SLVERR   2'h2

`endif

/* File: rtl/tmc_edge.v */
// Pin edge detector for channel 0 input capture
`timescale 1ns/1ps
module tmc_edge (
    aclk,       // System clock
    aresetn,    // Synchronous reset, active low
    pin_in,     // Channel pin level
    els,        // Edge/level select field
    edge_hit    // Selected edge seen this cycle
);
    input  wire       aclk;
    input  wire       aresetn;
    input  wire       pin_in;
    input  wire [1:0] els;
    output wire       edge_hit;

    reg pin_prev_reg;

    // Previous pin level; reset level low, so a pin high at reset gives
    // one rising edge, masked in tmc_top because the edge select resets to 00
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_in;
        end
    end

    // Bit A enables rising, bit B enables falling, both for either
    assign edge_hit = (els[0] & pin_in & ~pin_prev_reg) |
                      (els[1] & ~pin_in & pin_prev_reg); // [RULE18]

endmodule // tmc_edge

/* File: rtl/tmc_top.v */
// Timer counter with modulo limit and channel 0 status and control
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tmc_defs.vh"
module tmc_top #(
    parameter ADDR_W = 8        // AXI address width
) (
    aclk,                       // System clock, 100 MHz
    aresetn,                    // Synchronous reset, active low
    s_axi_awaddr,               // Write address
    s_axi_awvalid,              // Write address valid
    s_axi_awready,              // Write address ready
    s_axi_wdata,                // Write data
    s_axi_wstrb,                // Write byte strobes
    s_axi_wvalid,               // Write data valid
    s_axi_wready,               // Write data ready
    s_axi_bresp,                // Write response
    s_axi_bvalid,               // Write response valid
    s_axi_bready,               // Write response ready
    s_axi_araddr,               // Read address
    s_axi_arvalid,              // Read address valid
    s_axi_arready,              // Read address ready
    s_axi_rdata,                // Read data
    s_axi_rresp,                // Read response
    s_axi_rvalid,               // Read data valid
    s_axi_rready,               // Read data ready
    count_tick,                 // Counter enable
    counter_clear,              // Counter clear
    center_align_select,        // Up/down counting
    chan_value,                 // Channel 0 value
    pin_in,                     // Pin level
    pin_out,                    // Pin drive value
    pin_oe_n,                   // Pin drive, low
    counter_value,              // Counter value
    overflow_event,             // Overflow pulse
    capture_strobe,             // Capture pulse
    chan_irq                    // Channel request
);
    input  wire              aclk;
    input  wire              aresetn;
    input  wire [ADDR_W-1:0] s_axi_awaddr;
    input  wire              s_axi_awvalid;
    output reg               s_axi_awready;
    input  wire [31:0]       s_axi_wdata;
    input  wire [3:0]        s_axi_wstrb;
    input  wire              s_axi_wvalid;
    output reg               s_axi_wready;
    output reg  [1:0]        s_axi_bresp;
    output reg               s_axi_bvalid;
    input  wire              s_axi_bready;
    input  wire [ADDR_W-1:0] s_axi_araddr;
    input  wire              s_axi_arvalid;
    output reg               s_axi_arready;
    output reg  [31:0]       s_axi_rdata;
    output reg  [1:0]        s_axi_rresp;
    output reg               s_axi_rvalid;
    input  wire              s_axi_rready;
    input  wire              count_tick;
    input  wire              counter_clear;
    input  wire              center_align_select;
    input  wire [15:0]       chan_value;
    input  wire              pin_in;
    output reg               pin_out;
    output reg               pin_oe_n;
    output reg  [15:0]       counter_value;
    output reg               overflow_event;
    output reg               capture_strobe;
    output reg               chan_irq;

    ////////////////////////////////////////////////////////////////////////
    // Address decoder shared by read and write paths
    function [1:0] tmc_decode;
        input [ADDR_W-1:0] addr;
        begin
            if (addr[1:0] != 2'h0) begin
                tmc_decode = `TMC_SEL_NONE;
            end else if (addr[ADDR_W-1:2] == `TMC_IDX_MODH) begin
                tmc_decode = `TMC_SEL_MODH;
            end else if (addr[ADDR_W-1:2] == `TMC_IDX_MODL) begin
                tmc_decode = `TMC_SEL_MODL;
            end else if (addr[ADDR_W-1:2] == `TMC_IDX_CTRL) begin
                tmc_decode = `TMC_SEL_CTRL;
            end else begin
                tmc_decode = `TMC_SEL_NONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    reg  [15:0]       mod_reg;
    reg               flag_reg;
    reg  [6:2]        ctrl_reg;      // Control bits at their byte places
    reg               arm_reg;       // Qualifying read seen with flag set
    reg               mod_pend_reg;  // One modulo byte written, waiting
    reg               mod_hi_reg;    // Pending byte was the high one
    reg               dir_down_reg;
    reg  [ADDR_W-1:0] awaddr_reg;
    reg               aw_have_reg;
    reg  [7:0]        wdata_reg;
    reg               wlane_reg;
    reg               w_have_reg;

    wire [1:0] els      = ctrl_reg[`TMC_BIT_ELSB:`TMC_BIT_ELSA];
    wire [1:0] ms       = ctrl_reg[`TMC_BIT_MSB:`TMC_BIT_MSA];
    wire       cap_mode = ~center_align_select &
                          (ms == `TMC_MS_CAPTURE);        // [RULE15]
    wire       oc_mode  = ~center_align_select &
                          (ms == `TMC_MS_COMPARE);        // [RULE15]
    wire       epwm     = ~center_align_select &
                          ctrl_reg[`TMC_BIT_MSB];         // [RULE14]
    wire       pin_used = (els != `TMC_ELS_OFF);          // [RULE17]
    wire       edge_hit;

    tmc_edge u_edge (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .pin_in   (pin_in),
        .els      (els),
        .edge_hit (edge_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Counter limit and events
    wire [15:0] top   = (mod_reg == `TMC_CNT_ZERO) ? `TMC_CNT_FULL
                                                    : mod_reg; // [RULE4]
    wire        at_top = (counter_value == top);
    wire        match  = count_tick & (counter_value == chan_value);
    wire        wrap   = count_tick & ~center_align_select & at_top;
    wire        turn   = count_tick & center_align_select & ~dir_down_reg &
                         at_top;
    // Capture on edges; compare and both PWM kinds on every match
    wire        chan_event = cap_mode ? (pin_used & edge_hit)   // [RULE6]
                                      : match;        // [RULE7] [RULE8]

    // Counter, one step per tick
    always @(posedge aclk) begin
        if (!aresetn) begin
            counter_value <= `TMC_CNT_ZERO;
            dir_down_reg  <= 1'b0;
        end else if (counter_clear) begin
            counter_value <= `TMC_CNT_ZERO;
            dir_down_reg  <= 1'b0;
        end else if (count_tick) begin
            if (!center_align_select) begin
                dir_down_reg <= 1'b0;
                if (at_top) begin
                    counter_value <= `TMC_CNT_ZERO;           // [RULE1]
                end else begin
                    counter_value <= counter_value + `TMC_CNT_ONE;
                end
            end else if (!dir_down_reg) begin
                if (at_top) begin
                    dir_down_reg  <= 1'b1;                    // [RULE2]
                    counter_value <= counter_value - `TMC_CNT_ONE;
                end else begin
                    counter_value <= counter_value + `TMC_CNT_ONE;
                end
            end else begin
                if (counter_value == `TMC_CNT_ZERO) begin
                    dir_down_reg  <= 1'b0;
                    counter_value <= counter_value + `TMC_CNT_ONE;
                end else begin
                    counter_value <= counter_value - `TMC_CNT_ONE;
                end
            end
        end
    end

    // Overflow pulse, held off while a modulo update is half done
    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_event <= 1'b0;
        end else begin
            overflow_event <= (wrap | turn) & ~counter_clear &
                              ~mod_pend_reg;      // [RULE1] [RULE2] [RULE3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; flops so the pin never glitches on decode changes
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_out  <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_oe_n <= ~(pin_used & ~cap_mode);             // [RULE17]
            if (pin_used && oc_mode && match) begin
                case (els)                                   // [RULE19]
                    `TMC_ELS_TOGGLE: pin_out <= ~pin_out;
                    `TMC_ELS_CLEAR:  pin_out <= 1'b0;
                    `TMC_ELS_SET:    pin_out <= 1'b1;
                    default:         pin_out <= pin_out;
                endcase
            end else if (pin_used && epwm && match) begin
                pin_out <= els[0];                           // [RULE20]
            end else if (pin_used && epwm && wrap) begin
                pin_out <= ~els[0];                          // [RULE16]
            end else if (pin_used && center_align_select && match) begin
                // Up-count match ends the pulse, down-count match starts it
                pin_out <= els[0] ^ dir_down_reg;            // [RULE20]
            end
        end
    end

    // Channel interrupt request and capture pulse
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_irq       <= 1'b0;
            capture_strobe <= 1'b0;
        end else begin
            chan_irq       <= flag_reg & ctrl_reg[`TMC_BIT_IE]; // [RULE9]
            capture_strobe <= cap_mode & pin_used & edge_hit;   // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI write channel capture; address and data taken in either order
    wire        wr_go  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    wire [1:0]  wr_sel = tmc_decode(awaddr_reg);
    wire        wr_en  = wr_go & wlane_reg;
    wire [1:0]  rd_sel = tmc_decode(s_axi_araddr);
    wire        rd_go  = s_axi_arvalid & s_axi_arready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            awaddr_reg    <= {ADDR_W{1'b0}};
            wdata_reg     <= 8'h00;
            wlane_reg     <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TMC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg    <= s_axi_awaddr;
                aw_have_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg    <= s_axi_wdata[7:0];
                wlane_reg    <= s_axi_wstrb[0];
                w_have_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == `TMC_SEL_NONE) ?
                                `TMC_RESP_SLVERR : `TMC_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Modulo bytes and half-written tracking
    always @(posedge aclk) begin
        if (!aresetn) begin
            mod_reg      <= `TMC_MOD_RST;                    // [RULE4]
            mod_pend_reg <= 1'b0;
            mod_hi_reg   <= 1'b0;
        end else if (wr_en && wr_sel == `TMC_SEL_MODH) begin
            mod_reg[15:8] <= wdata_reg;                      // [RULE21]
            mod_pend_reg  <= ~(mod_pend_reg & ~mod_hi_reg);  // [RULE3]
            mod_hi_reg    <= 1'b1;
        end else if (wr_en && wr_sel == `TMC_SEL_MODL) begin
            mod_reg[7:0]  <= wdata_reg;                      // [RULE21]
            mod_pend_reg  <= ~(mod_pend_reg & mod_hi_reg);   // [RULE3]
            mod_hi_reg    <= 1'b0;
        end
    end

    // Channel control and event flag; a new event beats the clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `TMC_CTRL_RST;                       // [RULE13]
            flag_reg <= 1'b0;                                // [RULE12]
            arm_reg  <= 1'b0;
        end else begin
            if (wr_en && wr_sel == `TMC_SEL_CTRL) begin
                ctrl_reg <= wdata_reg[`TMC_BIT_IE:`TMC_BIT_ELSA]; // [RULE13]
            end
            if (chan_event) begin
                flag_reg <= 1'b1;                  // [RULE6] [RULE7] [RULE8]
                arm_reg  <= 1'b0;                            // [RULE11]
            end else if (wr_en && wr_sel == `TMC_SEL_CTRL) begin
                // Writing one leaves the flag alone
                if (arm_reg && !wdata_reg[`TMC_BIT_FLAG]) begin
                    flag_reg <= 1'b0;                        // [RULE10]
                end
                arm_reg <= 1'b0;                             // [RULE12]
            end else if (rd_go && rd_sel == `TMC_SEL_CTRL && flag_reg) begin
                arm_reg <= 1'b1;                             // [RULE10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read channel, one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `TMC_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `TMC_RESP_OKAY;
            case (rd_sel)
                `TMC_SEL_MODH: s_axi_rdata <= {24'h000000, mod_reg[15:8]};
                `TMC_SEL_MODL: s_axi_rdata <= {24'h000000, mod_reg[7:0]};
                `TMC_SEL_CTRL: s_axi_rdata <= {24'h000000, flag_reg,
                                               ctrl_reg, 2'h0}; // [RULE21]
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `TMC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // tmc_top

/* File: test/tmc_assertions.sv */
// Port-level checker for the timer modulo and channel 0 block
`timescale 1ns/1ps
module tmc_assertions #(
    parameter int ADDR_W = 8                // Bus address width
) (
    input logic              aclk,            // Clock
    input logic              aresetn,         // Reset, active low
    input logic              s_axi_awvalid,   // AW valid
    input logic              s_axi_awready,   // AW ready
    input logic              s_axi_wvalid,    // W valid
    input logic              s_axi_wready,    // W ready
    input logic              s_axi_bvalid,    // B valid
    input logic              s_axi_bready,    // B ready
    input logic [ADDR_W-1:0] s_axi_araddr,    // AR address
    input logic              s_axi_arvalid,   // AR valid
    input logic              s_axi_arready,   // AR ready
    input logic [31:0]       s_axi_rdata,     // R data
    input logic              s_axi_rvalid,    // R valid
    input logic              s_axi_rready,    // R ready
    input logic              count_tick,      // Counter enable
    input logic              counter_clear,   // Counter clear
    input logic              center_align_select, // Up/down mode
    input logic [15:0]       counter_value,   // Counter
    input logic              overflow_event,  // Overflow pulse
    input logic              capture_strobe,  // Capture pulse
    input logic              chan_irq         // Channel request
);
    logic [ADDR_W-1:0] rd_addr_reg;           // Target of the open read

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Remember the read target so read data can be judged per register
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    aw_busy_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    b_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    r_latency_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
    ctrl_low_a: assert property (
        s_axi_rvalid && rd_addr_reg == 8'h54
        |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[1:0] == 2'h0)
        else $error("control reserved bits not zero");
    wrap_zero_a: assert property (
        overflow_event && !center_align_select && !$past(center_align_select)
        |-> counter_value == 16'h0000) else $error("no wrap to zero");
    step_up_a: assert property (
        count_tick && !counter_clear && !center_align_select
        |=> counter_value == $past(counter_value) + 16'h0001
        || counter_value == 16'h0000) else $error("bad up count step");
    clear_zero_a: assert property (counter_clear
        |=> counter_value == 16'h0000 && !overflow_event)
        else $error("clear not honoured");

    // Main scenarios reached
    cover property (overflow_event && center_align_select);
    cover property (capture_strobe);
    cover property (chan_irq);
endmodule // tmc_assertions

/* File: test/tmc_pin_model.sv */
// External source on the channel pin, resolved against the block drive
`timescale 1ns/1ps
module tmc_pin_model (
    input  logic pin_out,     // Block drive value
    input  logic pin_oe_n,    // Low while the block drives
    input  logic ext_level,   // Level of the outside source
    output logic pin_in       // Resolved pin level
);
    // Outside source yields while the block drives, avoiding contention
    assign pin_in = pin_oe_n ? ext_level : pin_out;
endmodule // tmc_pin_model

/* File: test/timer_modulo_channel_control_bench.sv */
// Self-checking bench for the timer modulo and channel 0 block
`timescale 1ns/1ps
module timer_modulo_channel_control_bench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, count_tick;
    logic        counter_clear, center_align_select, pin_out, pin_oe_n;
    logic        overflow_event, capture_strobe, chan_irq, ext_level;
    wire         pin_in;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] chan_value, counter_value;
    int          error_cnt, num_checks, n;

    tmc_top #(.ADDR_W(8)) i_tmc_top (.*);
    tmc_pin_model i_tmc_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_level(ext_level), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic test_done;
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Bounded wait; running out fails the run
    task automatic tick(input int lim);
        if (n >= lim) begin
            error_cnt++;
            $display("wrong value at %0t: wait ran out", $time);
            test_done;
        end
        n++;
    endtask

    // Write; each channel released when taken
    task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            tick(50);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            tick(50);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
    endtask

    // Pin level step, then settle
    task automatic pin_edge(input logic v);
        @(posedge aclk);
        ext_level <= v;
        repeat (4) @(posedge aclk);
    endtask

    // Ticks from a counter clear to the first overflow pulse
    task automatic ovf_gap(input logic ctr, input logic [15:0] ev);
        @(posedge aclk);
        center_align_select <= ctr;
        counter_clear       <= 1'b1;
        @(posedge aclk);
        counter_clear <= 1'b0;
        count_tick    <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            tick(100);
        end while (overflow_event !== 1'b1);
        chk(n, 6);
        chk(counter_value, ev);
    endtask

    task automatic t_regs;
        rd(8'h4C, 32'h0, 2'h0);
        rd(8'h50, 32'h0, 2'h0);
        rd(8'h54, 32'h0, 2'h0);
        rd(8'h58, 32'h0, 2'h2);
        wr(8'h58, 8'hFF, 2'h2);
        wr(8'h4C, 8'h12, 2'h0);
        wr(8'h50, 8'h34, 2'h0);
        rd(8'h4C, 32'h12, 2'h0);
        rd(8'h50, 32'h34, 2'h0);
        wr(8'h54, 8'h7F, 2'h0);
        rd(8'h54, 32'h7C, 2'h0);
        wr(8'h54, 8'h00, 2'h0);
        wr(8'h4C, 8'h00, 2'h0);
        wr(8'h50, 8'h05, 2'h0);
    endtask

    // One modulo byte alone holds back overflow
    task automatic t_pending;
        int k;
        wr(8'h4C, 8'h00, 2'h0);
        k = 0;
        repeat (20) begin
            @(posedge aclk);
            #1;
            if (overflow_event === 1'b1) k++;
        end
        chk(k, 0);
        wr(8'h50, 8'h05, 2'h0);
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            tick(20);
        end while (overflow_event !== 1'b1);
    endtask

    task automatic t_compare;
        @(posedge aclk);
        chan_value          <= 16'h0003;
        center_align_select <= 1'b0;
        counter_clear       <= 1'b1;
        @(posedge aclk);
        counter_clear <= 1'b0;
        wr(8'h54, 8'h54, 2'h0);
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            tick(30);
        end while (chan_irq !== 1'b1);
        chk(pin_oe_n, 1'b0);
        chk(pin_out, 1'b1);
        @(posedge aclk);
        count_tick <= 1'b0;
        wr(8'h54, 8'h54, 2'h0);
        rd(8'h54, 32'hD4, 2'h0);
        wr(8'h54, 8'hD4, 2'h0);
        rd(8'h54, 32'hD4, 2'h0);
        wr(8'h54, 8'h54, 2'h0);
        rd(8'h54, 32'h54, 2'h0);
        chk(chan_irq, 1'b0);
    endtask

    task automatic t_capture;
        wr(8'h54, 8'h50, 2'h0);
        repeat (2) @(posedge aclk);
        chk(pin_oe_n, 1'b1);
        wr(8'h54, 8'h48, 2'h0);
        pin_edge(1'b1);
        chk(pin_oe_n, 1'b1);
        rd(8'h54, 32'h48, 2'h0);
        pin_edge(1'b0);
        rd(8'h54, 32'hC8, 2'h0);
        chk(chan_irq, 1'b1);
        pin_edge(1'b1);
        pin_edge(1'b0);
        wr(8'h54, 8'h48, 2'h0);
        rd(8'h54, 32'hC8, 2'h0);
        wr(8'h54, 8'h48, 2'h0);
        rd(8'h54, 32'h48, 2'h0);
    endtask

    // Main sequence
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, count_tick, counter_clear, center_align_select,
         ext_level} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb,
         chan_value} = '0;
        error_cnt = 0;
        num_checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        ovf_gap(1'b0, 16'h0000);
        t_pending;
        ovf_gap(1'b1, 16'h0004);
        t_compare;
        t_capture;
        test_done;
    end
endmodule // timer_modulo_channel_control_bench

bind tmc_top tmc_assertions #(.ADDR_W(ADDR_W)) i_tmc_assertions (.*);
